// file: rtl/down_timer_pwm_tone_regs.svh
// Purpose: Register indices, field positions, reset values for the down timer.
// Assumes: Byte address of a register is four times its index.
// Notes: Only the low byte of each 32-bit word carries data.
`ifndef DOWN_TIMER_PWM_TONE_REGS_SVH
`define DOWN_TIMER_PWM_TONE_REGS_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define IDX_DOWN_COUNTER_VALUE 6'h00
`define IDX_TIMER_CONTROL_ONE 6'h01
`define IDX_TIMER_CONTROL_TWO 6'h02
`define IDX_PWM_DUTY_VALUE 6'h03
`define IDX_PRESCALE_COUNT_VALUE 6'h04
`define IDX_TONE_CONTROL 6'h05
`define IDX_TIMER_STATUS 6'h06

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_TIMER_RUN_ENABLE 0
`define BIT_RELOAD_FROM_VALUE_SELECT 1
`define BIT_SINGLE_PASS_SELECT 2
`define BIT_PWM_LOW_ACTIVE_SELECT 6
`define BIT_PWM_PIN_ENABLE 7
`define BIT_COUNT_SOURCE_SELECT 5
`define BIT_COUNT_EDGE_SELECT 4
`define BIT_PRESCALE_DISABLE_N 3
`define BIT_TONE_ENABLE 7
`define BIT_UNDERFLOW_FLAG 0

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define RST_TIMER_CONTROL_ONE 8'h00
`define RST_TIMER_CONTROL_TWO 6'h3F
`define RST_TONE_CONTROL 5'h0F
`define RST_DOWN_COUNTER 8'h00
`define RST_PWM_DUTY 8'h00
`define RST_PRESCALE 8'h00
`define COUNT_FLOOR 8'h00
`define COUNT_WRAP 8'hFF

`endif

// file: rtl/down_timer_pwm_tone_pkg.sv
// Purpose: Types shared by the down timer design and its bench.
// Assumes: Nothing beyond the register header.
// Notes: Holds types only; numbers live in the register header.
package down_timer_pwm_tone_pkg;

    typedef enum logic {
        src_instruction = 1'b0,
        src_external = 1'b1
    } count_source_t;

    typedef enum logic [1:0] {
        pin_gpio = 2'b00,
        pin_tone = 2'b01,
        pin_pwm = 2'b10
    } pin_owner_t;

    typedef logic [7:0] byte_t;

endpackage

// file: rtl/down_timer_pwm_tone.sv
// Purpose: 8-bit down timer with prescaler, PWM and tone output on one pin.
// Assumes: APB slave, zero wait states; pin inputs synchronous to pclk.
// Notes: Counter ticks are single-cycle enables derived inside pclk.
//
// Overview of operation
// [RQ1] Single-pass mode counts down to 0x00 once, then stops at underflow.
// [RQ2] Continuous with reload: underflow reloads the stored value and continues.
// [RQ3] Continuous without reload: underflow loads 0xFF and continues.
// [RQ4] After enabling, PWM stays inactive until the compare matches.
// [RQ5] Counter equal to duty makes PWM active until underflow.
// [RQ6] Polarity bit 1 gives active-low PWM, 0 gives active-high.
// [RQ7] PWM pin enable drives PB2 with PWM; clear leaves PB2 as GPIO. When clear, the code gives PB2 to the tone if tone enable is 1.
// [RQ8] Reload value sets PWM period, duty register sets duty.
// [RQ9] Source select 0 uses instruction clock, 1 uses external pin.
// [RQ10] External edge select 1 counts falling edges, 0 rising edges.
// [RQ11] Prescaler inserted when enable-low bit is 0; ratios 1:2 to 1:256.
// [RQ12] Software changes the ratio only while the prescaler is disabled.
// [RQ13] Prescale count register reads the live prescaler count.
// [RQ14] Tone codes 0000-0111 take prescaler output, 1:2 to 1:256.
// [RQ15] Tone codes 1000-1111 take counter bit 0 through bit 7.
// [RQ16] PWM duty register is write-only with undefined reset contents.
// [RQ17] Counter read returns live count; write loads reload and count.
// [RQ18] Underflow sets a sticky flag until firmware clears it.
// [RQ19] Counter advances only while the run enable bit is 1.
// [RQ20] Tone toggles on PB2 only while tone enable is 1.
// [RQ21] Underflow is detected on the tick that decrements from 0x00.
//
// Our own choice: the APB register port.
`include "down_timer_pwm_tone_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module down_timer_pwm_tone (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_count_input,
    input wire logic gpio_pin_out,
    input wire logic gpio_pin_oe,
    output logic pin_out,
    output logic pin_oe,
    output logic underflow_flag
);
    import down_timer_pwm_tone_pkg::*;

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic timer_run_enable;
    logic reload_from_value_select;
    logic single_pass_select;
    logic pwm_low_active_select;
    logic pwm_pin_enable;
    count_source_t count_source_select;
    logic count_edge_select;
    logic prescale_disable_n;
    logic [2:0] prescale_ratio_select;
    byte_t pwm_duty_value;
    byte_t reload_value;
    byte_t down_counter_value;
    byte_t prescale_count_value;
    logic tone_enable;
    logic [3:0] tone_ratio_select;
    logic stopped;
    logic pwm_active;
    logic ext_prev;

    logic wr_access;
    logic src_tick;
    logic ps_tick;
    logic count_tick;
    logic underflow;
    logic [7:0] ps_mask;
    logic tone_level;
    pin_owner_t pin_owner;

    // Word index of a byte address; the low two bits must be zero.
    function automatic logic addr_is(input logic [7:0] addr, input logic [5:0] idx);
        addr_is = (addr[1:0] == 2'b00) && (addr[7:2] == idx);
    endfunction

    function automatic logic addr_mapped(input logic [7:0] addr);
        addr_mapped = (addr[1:0] == 2'b00) && (addr[7:2] <= `IDX_TIMER_STATUS);
    endfunction

    assign wr_access = psel && penable && pwrite && pstrb[0];

    // ****************************************************************
    // Count source and prescaler
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= external_count_input;
        end
    end

    always_comb begin
        if (count_source_select == src_external) begin // see [RQ9]
            if (count_edge_select) begin // see [RQ10]
                src_tick = ext_prev && !external_count_input;
            end else begin
                src_tick = !ext_prev && external_count_input;
            end
        end else begin
            src_tick = 1'b1;
        end
    end

    // A ratio of 2^(n+1) ticks when the low n+1 prescaler bits are all ones.
    assign ps_mask = 8'(({1'b0, 8'h01} << ({1'b0, prescale_ratio_select} + 4'h1)) - 9'h001);
    assign ps_tick = src_tick && ((prescale_count_value & ps_mask) == ps_mask); // see [RQ11]
    assign count_tick = (prescale_disable_n ? src_tick : ps_tick)
                        && timer_run_enable && !stopped; // see [RQ19]
    assign underflow = count_tick && (down_counter_value == `COUNT_FLOOR); // see [RQ21]

    // Changing the ratio while running can hit the mask early; software avoids it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_count_value <= `RST_PRESCALE;
        end else if (!prescale_disable_n && src_tick) begin // see [RQ13]
            prescale_count_value <= prescale_count_value + 8'h01;
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {pwm_pin_enable, pwm_low_active_select} <= 2'b00;
            {single_pass_select, reload_from_value_select, timer_run_enable} <= 3'b000;
        end else if (wr_access && addr_is(paddr, `IDX_TIMER_CONTROL_ONE)) begin
            pwm_pin_enable <= pwdata[`BIT_PWM_PIN_ENABLE];
            pwm_low_active_select <= pwdata[`BIT_PWM_LOW_ACTIVE_SELECT];
            single_pass_select <= pwdata[`BIT_SINGLE_PASS_SELECT];
            reload_from_value_select <= pwdata[`BIT_RELOAD_FROM_VALUE_SELECT];
            timer_run_enable <= pwdata[`BIT_TIMER_RUN_ENABLE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // The source select is an enum, so its reset bit goes in through a cast.
            count_source_select <= count_source_t'(1'(`RST_TIMER_CONTROL_TWO >> 5));
            {count_edge_select, prescale_disable_n, prescale_ratio_select} <=
                5'(`RST_TIMER_CONTROL_TWO);
        end else if (wr_access && addr_is(paddr, `IDX_TIMER_CONTROL_TWO)) begin
            count_source_select <= count_source_t'(pwdata[`BIT_COUNT_SOURCE_SELECT]);
            count_edge_select <= pwdata[`BIT_COUNT_EDGE_SELECT];
            prescale_disable_n <= pwdata[`BIT_PRESCALE_DISABLE_N];
            prescale_ratio_select <= pwdata[2:0];
        end
    end

    // Duty has no defined reset value to software; it is cleared for determinism.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_duty_value <= `RST_PWM_DUTY;
        end else if (wr_access && addr_is(paddr, `IDX_PWM_DUTY_VALUE)) begin // see [RQ16]
            pwm_duty_value <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {tone_enable, tone_ratio_select} <= `RST_TONE_CONTROL;
        end else if (wr_access && addr_is(paddr, `IDX_TONE_CONTROL)) begin
            tone_enable <= pwdata[`BIT_TONE_ENABLE];
            tone_ratio_select <= pwdata[3:0];
        end
    end

    // ****************************************************************
    // Down counter
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            down_counter_value <= `RST_DOWN_COUNTER;
            reload_value <= `RST_DOWN_COUNTER;
            stopped <= 1'b0;
        end else if (wr_access && addr_is(paddr, `IDX_DOWN_COUNTER_VALUE)) begin
            down_counter_value <= pwdata[7:0]; // see [RQ17]
            reload_value <= pwdata[7:0];
            stopped <= 1'b0;
        end else if (underflow) begin
            if (single_pass_select) begin
                stopped <= 1'b1; // see [RQ1]
            end else if (reload_from_value_select) begin
                down_counter_value <= reload_value; // see [RQ2]
            end else begin
                down_counter_value <= `COUNT_WRAP; // see [RQ3]
            end
        end else if (count_tick) begin
            down_counter_value <= down_counter_value - 8'h01;
        end
    end

    // Setting wins over a clear that lands in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            underflow_flag <= 1'b0;
        end else if (underflow) begin
            underflow_flag <= 1'b1; // see [RQ18]
        end else if (wr_access && addr_is(paddr, `IDX_TIMER_STATUS)
                     && pwdata[`BIT_UNDERFLOW_FLAG]) begin
            underflow_flag <= 1'b0;
        end
    end

    // ****************************************************************
    // PWM and tone
    // ****************************************************************
    // Period follows the reload value and duty the compare value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_active <= 1'b0;
        end else if (!timer_run_enable || underflow) begin
            pwm_active <= 1'b0; // see [RQ4]
        end else if (down_counter_value == pwm_duty_value) begin
            pwm_active <= 1'b1; // see [RQ5] [RQ8]
        end
    end

    always_comb begin
        if (tone_ratio_select[3]) begin
            tone_level = down_counter_value[tone_ratio_select[2:0]]; // see [RQ15]
        end else begin
            tone_level = prescale_count_value[tone_ratio_select[2:0]]; // see [RQ14]
        end
    end

    // PWM outranks the tone, and both outrank ordinary port use of the pin.
    always_comb begin
        if (pwm_pin_enable) begin
            pin_owner = pin_pwm; // see [RQ7]
        end else if (tone_enable) begin
            pin_owner = pin_tone; // see [RQ20]
        end else begin
            pin_owner = pin_gpio;
        end
    end

    // The pin is a flop so the pad never sees decode glitches.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            case (pin_owner)
                pin_pwm: begin
                    pin_out <= pwm_active ^ pwm_low_active_select; // see [RQ6] [RQ7]
                    pin_oe <= 1'b1;
                end
                pin_tone: begin
                    pin_out <= tone_level; // see [RQ20]
                    pin_oe <= 1'b1;
                end
                default: begin
                    pin_out <= gpio_pin_out; // see [RQ7]
                    pin_oe <= gpio_pin_oe;
                end
            endcase
        end
    end

    // ****************************************************************
    // APB read path
    // ****************************************************************
    // Read data is captured in the setup cycle so the access phase is zero-wait.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (psel && !penable) begin
                pslverr <= !addr_mapped(paddr);
                if (addr_is(paddr, `IDX_DOWN_COUNTER_VALUE)) begin
                    prdata <= {24'h000000, down_counter_value}; // see [RQ17]
                end else if (addr_is(paddr, `IDX_TIMER_CONTROL_ONE)) begin
                    prdata <= {29'h00000000, single_pass_select,
                               reload_from_value_select, timer_run_enable};
                end else if (addr_is(paddr, `IDX_TIMER_CONTROL_TWO)) begin
                    prdata <= {26'h0000000, count_source_select, count_edge_select,
                               prescale_disable_n, prescale_ratio_select};
                end else if (addr_is(paddr, `IDX_PRESCALE_COUNT_VALUE)) begin
                    prdata <= {24'h000000, prescale_count_value}; // see [RQ13]
                end else if (addr_is(paddr, `IDX_TIMER_STATUS)) begin
                    prdata <= {31'h00000000, underflow_flag};
                end else begin
                    prdata <= 32'h00000000;
                end
            end
        end
    end

endmodule

`default_nettype wire

// file: test/down_timer_pwm_tone_properties.sv
// Purpose: Port-level checks for the down timer.
// Assumes: Zero-wait APB slave; the bench holds pstrb high.
// Notes: Pin enable bits are shadowed from bus writes.
`include "down_timer_pwm_tone_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module down_timer_pwm_tone_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic external_count_input,
    input wire logic gpio_pin_out,
    input wire logic gpio_pin_oe,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic underflow_flag
);
    // ****************************************************************
    // Shadows and properties
    // ****************************************************************
    localparam logic [7:0] a_c1 = {`IDX_TIMER_CONTROL_ONE, 2'b00};
    localparam logic [7:0] a_tn = {`IDX_TONE_CONTROL, 2'b00};
    localparam logic [7:0] a_st = {`IDX_TIMER_STATUS, 2'b00};
    localparam logic [7:0] a_dt = {`IDX_PWM_DUTY_VALUE, 2'b00};
    logic wr;
    logic setup;
    logic pwm_en;
    logic tone_en;
    logic [1:0] age;
    assign wr = psel && penable && pwrite && pstrb[0];
    assign setup = psel && !penable;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_en <= 1'b0;
            tone_en <= 1'b0;
        end else if (wr && paddr == a_c1) begin
            pwm_en <= pwdata[`BIT_PWM_PIN_ENABLE];
        end else if (wr && paddr == a_tn) begin
            tone_en <= pwdata[`BIT_TONE_ENABLE];
        end
    end
    // The pin path is registered, so pass-through is judged only once it has settled.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age <= 2'd0;
        end else if (pwm_en || tone_en || $changed({gpio_pin_out, gpio_pin_oe})) begin
            age <= 2'd0;
        end else if (age != 2'd3) begin
            age <= age + 2'd1;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low in access phase");
    property p_bad;
        setup && (paddr[7:2] > `IDX_TIMER_STATUS || paddr[1:0] != 2'b00)
            |=> pslverr && prdata == 32'h0;
    endproperty
    a_bad: assert property (p_bad) else $error("bad address not refused");
    property p_wo;
        setup && (paddr == a_dt || paddr == a_tn) |=> prdata == 32'h0;
    endproperty
    a_wo: assert property (p_wo) else $error("write-only register read nonzero");
    property p_upper;
        psel && penable |-> prdata[31:8] == 24'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_sticky;
        underflow_flag && !(wr && paddr == a_st && pwdata[0]) |=> underflow_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped uncleared");
    property p_gpio;
        age == 2'd3 |-> pin_oe == gpio_pin_oe && pin_out == gpio_pin_out;
    endproperty
    a_gpio: assert property (p_gpio) else $error("pin not following gpio");
    property p_pwm_oe;
        pwm_en && $past(pwm_en, 2) |-> pin_oe;
    endproperty
    a_pwm_oe: assert property (p_pwm_oe) else $error("pwm not driving pin");
    property p_tone_oe;
        tone_en && $past(tone_en, 2) |-> pin_oe;
    endproperty
    a_tone_oe: assert property (p_tone_oe) else $error("tone not driving pin");
    c_flag: cover property ($rose(underflow_flag));
    c_err: cover property (psel && penable && pslverr);
    c_pwm: cover property (pwm_en && $changed(pin_out));
endmodule
bind down_timer_pwm_tone down_timer_pwm_tone_properties u_props (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .external_count_input, .gpio_pin_out, .gpio_pin_oe, .pin_out, .pin_oe, .underflow_flag);
`default_nettype wire

// file: test/down_timer_pwm_tone_tb_top.sv
// Purpose: Self-checking bench for the down timer with PWM and tone.
// Assumes: Zero-wait APB answer; registered pin path.
// Notes: Table rows cover register access; timer cases follow by hand.
`include "down_timer_pwm_tone_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module down_timer_pwm_tone_tb_top;
    import down_timer_pwm_tone_pkg::*;
    // ****************************************************************
    // Signals, tasks and tests
    // ****************************************************************
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic external_count_input;
    logic gpio_pin_out;
    logic gpio_pin_oe;
    logic pin_out;
    logic pin_oe;
    logic underflow_flag;
    logic [31:0] q;
    logic e;
    byte_t v;
    logic [31:0] h;
    int n_fail = 0;
    int checks_done = 0;
    logic [5:0] ti [8] = '{`IDX_TIMER_CONTROL_TWO, `IDX_TIMER_CONTROL_ONE, `IDX_PWM_DUTY_VALUE,
        `IDX_TONE_CONTROL, `IDX_DOWN_COUNTER_VALUE, `IDX_PRESCALE_COUNT_VALUE, 6'h07,
        `IDX_TIMER_CONTROL_ONE};
    logic [1:0] tl [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1};
    logic [31:0] td [8] = '{32'h1B, 32'hC6, 32'hA5, 32'h0F, 32'h5A, 32'h77, 32'h33, 32'h11};
    logic [31:0] tq [8] = '{32'h1B, 32'h06, 32'h0, 32'h0, 32'h5A, 32'h0, 32'h0, 32'h0};
    logic te [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    down_timer_pwm_tone dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .external_count_input, .gpio_pin_out,
        .gpio_pin_oe, .pin_out, .pin_oe, .underflow_flag);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_fail++;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] i, input logic [31:0] d);
        apb(1'b1, {i, 2'b00}, d);
    endtask
    task automatic rd(input logic [5:0] i);
        apb(1'b0, {i, 2'b00}, 32'h0);
    endtask
    task automatic hc(input int n);
        repeat (3) @(posedge pclk);
        h = 0;
        repeat (n) begin
            @(posedge pclk);
            h = h + 32'(pin_out);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // The whole sequence needs about 5000 cycles, so this leaves a wide margin.
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        final_report();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        external_count_input = 1'b0;
        gpio_pin_out = 1'b0;
        gpio_pin_oe = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, {ti[i], tl[i]}, td[i]);
            apb(1'b0, {ti[i], tl[i]}, 32'h0);
            check(q, tq[i]);
            check(32'(e), 32'(te[i]));
        end
        $display("test registers done");
        wr(`IDX_TIMER_CONTROL_TWO, 32'h08);
        for (int m = 0; m < 2; m++) begin
            wr(`IDX_DOWN_COUNTER_VALUE, 32'h03);
            wr(`IDX_TIMER_CONTROL_ONE, m ? 32'h01 : 32'h03);
            repeat (10) @(posedge pclk);
            wr(`IDX_TIMER_CONTROL_ONE, 32'h00);
            rd(`IDX_DOWN_COUNTER_VALUE);
            v = q[7:0];
            repeat (4) @(posedge pclk);
            rd(`IDX_DOWN_COUNTER_VALUE);
            check(q, {24'h0, v});
            check({28'h0, v[7:4]}, m ? 32'hF : 32'h0);
        end
        $display("test continuous done");
        wr(`IDX_TIMER_STATUS, 32'h01);
        wr(`IDX_DOWN_COUNTER_VALUE, 32'h02);
        wr(`IDX_TIMER_CONTROL_ONE, 32'h05);
        repeat (8) @(posedge pclk);
        check(32'(underflow_flag), 32'h1);
        rd(`IDX_DOWN_COUNTER_VALUE);
        check(q, 32'h0);
        wr(`IDX_TIMER_STATUS, 32'h01);
        repeat (3) @(posedge pclk);
        check(32'(underflow_flag), 32'h0);
        $display("test single pass done");
        for (int b = 0; b < 2; b++) begin
            external_count_input <= ~b[0];
            wr(`IDX_TIMER_CONTROL_TWO, b ? 32'h38 : 32'h28);
            wr(`IDX_TIMER_STATUS, 32'h01);
            wr(`IDX_DOWN_COUNTER_VALUE, 32'h00);
            wr(`IDX_TIMER_CONTROL_ONE, 32'h05);
            external_count_input <= b[0];
            repeat (4) @(posedge pclk);
            check(32'(underflow_flag), 32'h0);
            external_count_input <= ~b[0];
            repeat (4) @(posedge pclk);
            check(32'(underflow_flag), 32'h1);
        end
        $display("test external edge done");
        wr(`IDX_TIMER_CONTROL_TWO, 32'h08);
        wr(`IDX_TIMER_CONTROL_ONE, 32'h00);
        wr(`IDX_PWM_DUTY_VALUE, 32'h04);
        wr(`IDX_DOWN_COUNTER_VALUE, 32'h09);
        wr(`IDX_TIMER_CONTROL_ONE, 32'h83);
        hc(3);
        check(h, 32'd0);
        for (int p = 0; p < 2; p++) begin
            wr(`IDX_TIMER_CONTROL_ONE, p ? 32'hC3 : 32'h83);
            hc(12);
            hc(20);
            check(h, p ? 32'd12 : 32'd8);
            check(32'(pin_oe), 32'h1);
        end
        $display("test pwm done");
        wr(`IDX_TIMER_CONTROL_ONE, 32'h01);
        wr(`IDX_TIMER_CONTROL_TWO, 32'h00);
        for (int c = 0; c < 16; c++) begin
            if (c == 8) begin
                rd(`IDX_PRESCALE_COUNT_VALUE);
                v = q[7:0];
                rd(`IDX_PRESCALE_COUNT_VALUE);
                check({24'h0, q[7:0] - v}, 32'h3);
                wr(`IDX_TIMER_CONTROL_TWO, 32'h08);
            end
            wr(`IDX_TONE_CONTROL, 32'h80 | 32'(c));
            hc(256);
            check(h, 32'd128);
        end
        // A 1:16 ratio over a 32-cycle window gives exactly two counter ticks.
        wr(`IDX_TIMER_CONTROL_TWO, 32'h0B);
        wr(`IDX_TIMER_CONTROL_TWO, 32'h03);
        rd(`IDX_DOWN_COUNTER_VALUE);
        v = q[7:0];
        repeat (29) @(posedge pclk);
        rd(`IDX_DOWN_COUNTER_VALUE);
        check({24'h0, v - q[7:0]}, 32'h2);
        gpio_pin_out <= 1'b1;
        gpio_pin_oe <= 1'b1;
        wr(`IDX_TONE_CONTROL, 32'h08);
        hc(20);
        check(h, 32'd20);
        check(32'(pin_oe), 32'h1);
        $display("test tone done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check({29'h0, pready, underflow_flag, pin_oe}, 32'h0);
        presetn <= 1'b1;
        rd(`IDX_TIMER_CONTROL_TWO);
        check(q, 32'h3F);
        rd(`IDX_DOWN_COUNTER_VALUE);
        check(q, 32'h0);
        $display("test reset done");
        final_report();
    end
endmodule
`default_nettype wire
